// *** hw/tw_defs.vh ***
// constants of the two-wire control port and its register file
`ifndef TW_DEFS_VH
`define TW_DEFS_VH
// ==========================================================
// two-wire slave address
`define TW_ADDR_HI       4'hd
`define TW_STRAP_LOW     2'h0
`define TW_STRAP_OPEN    2'h1
`define TW_STRAP_HIGH    2'h2
// ==========================================================
// control map
`define TW_LAST_REG      8'h08
`define TW_MAP_RESET     8'h00
`define TW_IDX_ENABLE    4'h5
`define TW_ENABLE_LSB    2
`define TW_ENABLE_PINS   2'h0
`define TW_ENABLE_IN0    2'h1
`define TW_ENABLE_IN1    2'h2
`define TW_ENABLE_BOTH   2'h3
`define TW_IDLE_BYTE     8'hff
// ==========================================================
// bus word indices (byte address is four times the index)
`define TW_IDX_CTRL      4'h9
`define TW_IDX_STATUS    4'ha
`define TW_CTRL_RESET    1'b0
// ==========================================================
// write queue
`define TW_FIFO_WIDTH    16
`define TW_FIFO_DEPTH    8
`define TW_FIFO_AW       3
`endif

// *** hw/tw_sync.v ***
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module tw_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1  <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else if (clkEn) begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** hw/tw_fifo.v ***
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module tw_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire             clkEn,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign inReady  = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk_sys) begin
    if (clkEn && push) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (clkEn) begin
      if (push) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** hw/tw_port.v ***
// two-wire slave control port, control map, bus slave, input enable
`timescale 1ns/100ps
`default_nettype none
`include "tw_defs.vh"
module tw_port (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        sclIn,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  input  wire [1:0]  addressStrapLow,
  input  wire [1:0]  addressStrapHigh,
  input  wire        input0SelectPin,
  input  wire        input1SelectPin,
  output reg         referenceInput0Enable,
  output reg         referenceInput1Enable,
  output reg         monitorEnable,
  output reg         threeWireSelect
);
  // ========================================================
  // states
  localparam ST_IDLE   = 4'h0;
  localparam ST_ADDR   = 4'h1;
  localparam ST_ACK    = 4'h2;
  localparam ST_PTR    = 4'h3;
  localparam ST_DATA   = 4'h4;
  localparam ST_TX     = 4'h5;
  localparam ST_MACK   = 4'h6;
  localparam ST_IGNORE = 4'h7;
  localparam ACK_ADDR  = 2'h0;
  localparam ACK_PTR   = 2'h1;
  localparam ACK_DATA  = 2'h2;

  // ========================================================
  // pin synchronisers
  wire [7:0] pinSync;
  wire       scl;
  wire       sda;
  wire [1:0] strapLo;
  wire [1:0] strapHi;
  wire       input0_select_pin;
  wire       input1_select_pin;

  tw_sync #(
    .WIDTH (8)
  ) uSync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clkEn   (clkEn),
    .asyncIn ({sclIn, sdaIn, addressStrapLow, addressStrapHigh,
               input0SelectPin, input1SelectPin}),
    .syncOut (pinSync)
  );

  assign scl     = pinSync[7];
  assign sda     = pinSync[6];
  assign strapLo = pinSync[5:4];
  assign strapHi = pinSync[3:2];
  assign input0_select_pin    = pinSync[1];
  assign input1_select_pin    = pinSync[0];

  // ========================================================
  // bus condition detect
  reg  sclPrev;
  reg  sdaPrev;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (clkEn) begin
      sclPrev <= scl;
      sdaPrev <= sda;
    end
  end

  assign sclRise   = scl & ~sclPrev;
  assign sclFall   = ~scl & sclPrev;
  assign startSeen = scl & sclPrev & sdaPrev & ~sda;
  assign stopSeen  = scl & sclPrev & ~sdaPrev & sda;

  // ========================================================
  // own address from three-level straps
  wire [3:0] strapSum;
  wire [6:0] ownAddr;
  wire       strapsHigh;

  assign strapSum   = {strapLo, 1'b0} + {2'b00, strapLo} + {2'b00, strapHi};
  assign ownAddr    = {`TW_ADDR_HI, strapSum[2:0]};
  assign strapsHigh = (strapLo == `TW_STRAP_HIGH) &&
                      (strapHi == `TW_STRAP_HIGH);

  // ========================================================
  // control map and write queue
  reg  [7:0]  mapReg [0:8];
  reg  [7:0]  pointer;
  reg  [7:0]  shiftIn;
  reg         pushValid;
  reg  [15:0] pushData;
  wire        pushReady;
  wire        drainValid;
  wire [15:0] drainData;
  wire        drainReady;
  reg         drainHold;
  reg         busWrPend;
  reg  [3:0]  busIdx;
  wire        busWr;

  tw_fifo #(
    .WIDTH (`TW_FIFO_WIDTH),
    .DEPTH (`TW_FIFO_DEPTH),
    .AW    (`TW_FIFO_AW)
  ) uFifo (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clkEn    (clkEn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainData)
  );

  // bus writes win the register file; the queue waits a cycle
  assign busWr      = busWrPend;
  assign drainReady = ~drainHold & ~busWr;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : gMap
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          mapReg[gi] <= `TW_MAP_RESET;
        end else if (clkEn) begin
          if (busWr && busIdx == gi) begin
            mapReg[gi] <= hwdata[7:0];
          end else if (drainValid && drainReady &&
                       drainData[15:8] == gi) begin
            mapReg[gi] <= drainData[7:0];
          end
        end
      end
    end
  endgenerate

  // ========================================================
  // two-wire slave engine
  reg  [3:0] state;
  reg  [3:0] bitCnt;
  reg  [1:0] ackKind;
  reg        ackGiven;
  reg        readDir;
  reg  [7:0] txShift;
  reg        mackOk;
  reg        busy;
  wire [7:0] nextPtr;
  wire [7:0] curByte;
  wire [7:0] nextByte;

  assign nextPtr  = (pointer < `TW_LAST_REG) ? pointer + 8'h01 : pointer;
  assign curByte  = (pointer <= `TW_LAST_REG) ? mapReg[pointer[3:0]] :
                    `TW_IDLE_BYTE;
  assign nextByte = (pointer < `TW_LAST_REG) ? mapReg[nextPtr[3:0]] :
                    `TW_IDLE_BYTE;

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      ackKind   <= ACK_ADDR;
      ackGiven  <= 1'b0;
      readDir   <= 1'b0;
      txShift   <= 8'h00;
      mackOk    <= 1'b0;
      shiftIn   <= 8'h00;
      pointer   <= 8'h00;
      pushValid <= 1'b0;
      pushData  <= 16'h0000;
      sdaOe     <= 1'b0;
      sdaOut    <= 1'b0;
      busy      <= 1'b0;
    end else if (clkEn) begin
      pushValid <= 1'b0;
      sdaOut    <= 1'b0;
      if (strapsHigh) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
        busy  <= 1'b0;
      end else if (startSeen) begin
        // a new start re-arms the port
        state  <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe  <= 1'b0;
        busy   <= 1'b1;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
        busy  <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_PTR, ST_DATA: begin
            if (sclRise) begin
              shiftIn <= {shiftIn[6:0], sda};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              state  <= ST_ACK;
              if (state == ST_ADDR) begin
                ackKind <= ACK_ADDR;
                readDir <= shiftIn[0];
                ackGiven <= (shiftIn[7:1] == ownAddr);
                sdaOe    <= (shiftIn[7:1] == ownAddr);
              end else if (state == ST_PTR) begin
                ackKind  <= ACK_PTR;
                pointer  <= shiftIn;
                ackGiven <= 1'b1;
                sdaOe    <= 1'b1;
              end else begin
                // full queue refuses the byte with no acknowledge
                ackKind   <= ACK_DATA;
                ackGiven  <= pushReady;
                sdaOe     <= pushReady;
                pushValid <= pushReady;
                pushData  <= {pointer, shiftIn};
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              if (!ackGiven) begin
                state <= ST_IGNORE;
              end else if (ackKind == ACK_ADDR && readDir) begin
                state   <= ST_TX;
                txShift <= curByte;
                sdaOe   <= ~curByte[7];
              end else if (ackKind == ACK_ADDR) begin
                state <= ST_PTR;
              end else begin
                if (ackKind == ACK_DATA) begin
                  pointer <= pointer + 8'h01;
                end
                state <= ST_DATA;
              end
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt == 4'h7) begin
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
                state  <= ST_MACK;
              end else begin
                bitCnt  <= bitCnt + 4'h1;
                txShift <= {txShift[6:0], 1'b1};
                sdaOe   <= ~txShift[6];
              end
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              mackOk <= ~sda;
            end else if (sclFall) begin
              if (mackOk) begin
                pointer <= nextPtr;
                txShift <= nextByte;
                sdaOe   <= ~nextByte[7];
                state   <= ST_TX;
              end else begin
                sdaOe <= 1'b0;
                state <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE: begin
            sdaOe <= 1'b0;
          end
          ST_IDLE: begin
            sdaOe <= 1'b0;
            busy  <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================
  // reference input enable decode
  wire [1:0] enField;
  reg        en0;
  reg        en1;

  assign enField = mapReg[`TW_IDX_ENABLE][`TW_ENABLE_LSB+1:`TW_ENABLE_LSB];

  always @* begin
    case (enField)
      `TW_ENABLE_PINS: begin
        en0 = input0_select_pin;
        en1 = input1_select_pin;
      end
      `TW_ENABLE_IN0: begin
        en0 = 1'b1;
        en1 = 1'b0;
      end
      `TW_ENABLE_IN1: begin
        en0 = 1'b0;
        en1 = 1'b1;
      end
      default: begin
        en0 = 1'b1;
        en1 = 1'b1;
      end
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      referenceInput0Enable <= 1'b0;
      referenceInput1Enable <= 1'b0;
      monitorEnable         <= 1'b0;
      threeWireSelect       <= 1'b0;
    end else if (clkEn) begin
      referenceInput0Enable <= en0;
      referenceInput1Enable <= en1;
      // monitor off if any input off
      monitorEnable         <= en0 & en1;
      threeWireSelect       <= strapsHigh;
    end
  end

  // ========================================================
  // AHB-Lite slave, zero wait states
  wire       busTake;
  reg [31:0] readMux;
  wire [3:0] takeIdx;

  assign busTake = hsel & hready & htrans[1];
  assign takeIdx = haddr[5:2];

  always @* begin
    readMux = 32'h00000000;
    if (haddr[31:6] == 26'h0000000) begin
      if (takeIdx <= `TW_LAST_REG) begin
        readMux = {24'h000000, mapReg[takeIdx]};
      end else if (takeIdx == `TW_IDX_CTRL) begin
        readMux = {31'h00000000, drainHold};
      end else if (takeIdx == `TW_IDX_STATUS) begin
        readMux = {9'h000, ownAddr, 6'h00, state,
                   referenceInput1Enable, referenceInput0Enable,
                   threeWireSelect, ~pushReady, drainValid, busy};
      end
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      busWrPend <= 1'b0;
      busIdx    <= 4'h0;
      drainHold <= `TW_CTRL_RESET;
    end else if (clkEn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (busWrPend && busIdx == `TW_IDX_CTRL) begin
        drainHold <= hwdata[0];
      end
      busWrPend <= busTake & hwrite & (haddr[31:6] == 26'h0000000);
      busIdx    <= takeIdx;
      if (busTake && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/tw_port_sva.sv ***
// checker of the two-wire control port at its bus and pins
`timescale 1ns/100ps
`default_nettype none
module tw_port_sva (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic [1:0]  addressStrapLow,
  input wire logic [1:0]  addressStrapHigh,
  input wire logic        referenceInput0Enable,
  input wire logic        referenceInput1Enable,
  input wire logic        monitorEnable,
  input wire logic        threeWireSelect
);
  // ==============================
  // helpers
  wire logic rdTaken = hsel && hready && htrans[1] && !hwrite;
  wire logic strapsHigh = addressStrapLow == 2'h2 && addressStrapHigh == 2'h2;
  wire logic [2:0] statusBits = {referenceInput1Enable,
                                 referenceInput0Enable, threeWireSelect};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==============================
  // assertions
  a_drive_never_high:
    assert property (sdaOe |-> sdaOut == 1'b0) else $error("data driven high");
  a_oe_moves_low:
    assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
    else $error("data enable moved with clock high");
  a_monitor_off:
    assert property ((!referenceInput0Enable || !referenceInput1Enable) [*2]
      |-> !monitorEnable) else $error("monitor on with an input off");
  a_three_wire_on:
    assert property (strapsHigh [*6] |-> threeWireSelect)
    else $error("three-wire port not chosen");
  a_three_wire_off:
    assert property (!strapsHigh [*6] |-> !threeWireSelect)
    else $error("three-wire port chosen wrongly");
  a_three_wire_quiet:
    assert property (threeWireSelect |-> !sdaOe) else $error("two-wire active");
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus not ready or okay");
  a_unmapped_zero:
    assert property (rdTaken && haddr[31:6] != 26'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_map_byte_wide:
    assert property (rdTaken && haddr < 32'h24 |=> hrdata[31:8] == 24'h0)
    else $error("map byte upper bits set");
  a_status_mirror:
    assert property (rdTaken && haddr == 32'h28 |=> hrdata[22:19] == 4'hd
      && hrdata[5:3] == $past(statusBits)) else $error("status mismatch");
  cover property ($rose(sdaOe));
  cover property (threeWireSelect);
  cover property (monitorEnable);
endmodule
bind tw_port tw_port_sva i_sva (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclIn(sclIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapLow(addressStrapLow),
  .addressStrapHigh(addressStrapHigh),
  .referenceInput0Enable(referenceInput0Enable),
  .referenceInput1Enable(referenceInput1Enable),
  .monitorEnable(monitorEnable), .threeWireSelect(threeWireSelect));
`default_nettype wire

// *** verif/tw_master.sv ***
// two-wire bus master model for the control port
`timescale 1ns/100ps
`default_nettype none
module tw_master (
  output var logic sclLine,
  output var logic sdaPull,
  input  wire logic sdaLine
);
  initial begin
    sclLine = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic startCond();
    #7 sdaPull = 1'b0;
    #80 sclLine = 1'b1;
    #80 sdaPull = 1'b1;
    #80 sclLine = 1'b0;
    #80;
  endtask
  task automatic stopCond();
    sdaPull = 1'b1;
    #80 sclLine = 1'b1;
    #80 sdaPull = 1'b0;
    #160;
  endtask
  task automatic bitIo(input logic b, output logic s);
    sdaPull = !b;
    #80 sclLine = 1'b1;
    #80 s = sdaLine;
    #80 sclLine = 1'b0;
    #80;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(d[i], ack);
    bitIo(1'b1, ack);
  endtask
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(last, s);
  endtask
endmodule
`default_nettype wire

// *** verif/tw_testbench.sv ***
// self-checking bench of the two-wire control port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ==============================
  // stimulus and wiring
  // straps open and high give address code 5
  localparam logic [6:0] OWN_ADDR = {4'hd, 3'h5};
  logic        clk_sys;
  logic        reset;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rdv;
  logic        input0SelectPin;
  logic        input1SelectPin;
  logic [1:0]  addressStrapLow;
  logic [1:0]  addressStrapHigh;
  logic        ackBit;
  logic [7:0]  got;
  int          badCount;
  int          compares;
  int          cycles;
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, sdaOut, sdaOe, sclLine, sdaPull;
  wire logic        referenceInput0Enable, referenceInput1Enable;
  wire logic        monitorEnable, threeWireSelect;
  wire logic        sdaLine = (sdaOe ? sdaOut : 1'b1) & !sdaPull;
  tw_port i_dut (.clk_sys(clk_sys), .reset(reset), .clkEn(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addressStrapLow(addressStrapLow), .addressStrapHigh(addressStrapHigh),
    .input0SelectPin(input0SelectPin), .input1SelectPin(input1SelectPin),
    .referenceInput0Enable(referenceInput0Enable),
    .referenceInput1Enable(referenceInput1Enable),
    .monitorEnable(monitorEnable), .threeWireSelect(threeWireSelect));
  tw_master i_master (.sclLine(sclLine), .sdaPull(sdaPull), .sdaLine(sdaLine));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      end_sim();
    end
  end
  // ==============================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      badCount++;
    end
  endtask
  task automatic edgeReady();
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    edgeReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    edgeReady();
    q = hrdata;
  endtask
  task automatic linkAck(input logic [7:0] d, input logic e);
    i_master.sendByte(d, ackBit);
    chk("link ack", e, ackBit);
  endtask
  task automatic drained();
    for (int n = 0; n < 40; n++) begin
      ahb(1'b0, 32'h28, 32'h0, rdv);
      if (rdv[1] === 1'b0) break;
    end
  endtask
  // ==============================
  // scenarios
  task automatic testEnables();
    for (int i = 0; i < 4; i++) begin
      input0SelectPin <= i[0];
      input1SelectPin <= i[1];
      repeat (8) @(posedge clk_sys);
      chk("ref0 pin", i[0], referenceInput0Enable);
      chk("ref1 pin", i[1], referenceInput1Enable);
      chk("monitor pin", i == 3, monitorEnable);
    end
    input0SelectPin <= 1'b0;
    input1SelectPin <= 1'b0;
    for (int f = 1; f < 4; f++) begin
      ahb(1'b1, 32'h14, 32'(f * 4), rdv);
      repeat (6) @(posedge clk_sys);
      ahb(1'b0, 32'h28, 32'h0, rdv);
      chk("field enables", f, rdv[5:4]);
      chk("own address", OWN_ADDR, rdv[22:16]);
      chk("monitor field", f == 3, monitorEnable);
    end
    ahb(1'b1, 32'h100, 32'hffffffff, rdv);
    ahb(1'b0, 32'h100, 32'h0, rdv);
    chk("unmapped", 32'h0, rdv);
  endtask
  task automatic testFill();
    ahb(1'b1, 32'h24, 32'h1, rdv);
    i_master.startCond();
    linkAck({OWN_ADDR, 1'b0}, 1'b0);
    linkAck(8'h00, 1'b0);
    for (int i = 0; i < 8; i++) linkAck(8'(8'h10 + i), 1'b0);
    linkAck(8'h99, 1'b1);
    i_master.stopCond();
    ahb(1'b0, 32'h28, 32'h0, rdv);
    chk("queue full", 3'h6, rdv[2:0]);
    ahb(1'b1, 32'h24, 32'h0, rdv);
    drained();
    for (int i = 0; i < 9; i++) begin
      ahb(1'b0, 32'(4 * i), 32'h0, rdv);
      chk("map byte", (i < 8) ? 32'h10 + i : 32'h0, rdv);
    end
  endtask
  task automatic testLinkWrite();
    i_master.startCond();
    linkAck({OWN_ADDR, 1'b0}, 1'b0);
    linkAck(8'h04, 1'b0);
    linkAck(8'h11, 1'b0);
    linkAck(8'h08, 1'b0);
    i_master.stopCond();
    drained();
    ahb(1'b0, 32'h10, 32'h0, rdv);
    chk("byte 4", 32'h11, rdv);
    repeat (6) @(posedge clk_sys);
    chk("ref0 off", 1'b0, referenceInput0Enable);
    chk("ref1 on", 1'b1, referenceInput1Enable);
  endtask
  task automatic testLinkRead();
    ahb(1'b1, 32'h1c, 32'h5a, rdv);
    ahb(1'b1, 32'h20, 32'hc3, rdv);
    i_master.startCond();
    linkAck({OWN_ADDR, 1'b0}, 1'b0);
    linkAck(8'h07, 1'b0);
    i_master.startCond();
    linkAck({OWN_ADDR, 1'b1}, 1'b0);
    i_master.recvByte(1'b0, got);
    chk("read 7", 8'h5a, got);
    i_master.recvByte(1'b0, got);
    chk("read 8", 8'hc3, got);
    i_master.recvByte(1'b1, got);
    chk("read past end", 8'hff, got);
    i_master.stopCond();
    ahb(1'b0, 32'h28, 32'h0, rdv);
    chk("idle after read", 1'b0, rdv[0]);
  endtask
  task automatic testWrongAddr();
    i_master.startCond();
    linkAck({OWN_ADDR ^ 7'h01, 1'b0}, 1'b1);
    linkAck(8'h04, 1'b1);
    linkAck(8'h77, 1'b1);
    i_master.stopCond();
    repeat (20) @(posedge clk_sys);
    ahb(1'b0, 32'h10, 32'h0, rdv);
    chk("byte 4 kept", 32'h11, rdv);
  endtask
  task automatic testThreeWire();
    addressStrapLow <= 2'h2;
    addressStrapHigh <= 2'h2;
    repeat (8) @(posedge clk_sys);
    chk("three wire", 1'b1, threeWireSelect);
    i_master.startCond();
    linkAck({OWN_ADDR, 1'b0}, 1'b1);
    i_master.stopCond();
    addressStrapLow <= 2'h1;
    repeat (8) @(posedge clk_sys);
    chk("two wire", 1'b0, threeWireSelect);
  endtask
  // ==============================
  // main sequence and verdict
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    input0SelectPin = 1'b0;
    input1SelectPin = 1'b0;
    addressStrapLow = 2'h1;
    addressStrapHigh = 2'h2;
    badCount = 0;
    compares = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (8) @(posedge clk_sys);
    testEnables();
    testFill();
    testLinkWrite();
    testLinkRead();
    testWrongAddr();
    testThreeWire();
    end_sim();
  end
endmodule
`default_nettype wire
